// >>> shared/bmsd_defs.svh
`ifndef BMSD_DEFS_SVH
`define BMSD_DEFS_SVH

// Field positions inside the latched configuration word.
`define BMSD_WORD_W        12
`define BMSD_SEL_LSB       0
`define BMSD_SEL_MSB       3
`define BMSD_PCI_BIT       4
`define BMSD_FAST_BIT      5
`define BMSD_AEM_LSB       6
`define BMSD_AEM_MSB       8
`define BMSD_PLLMS_LSB     9
`define BMSD_PLLMS_MSB     11

// Boot-select codes.
`define BMSD_SEL_EMU       4'h0
`define BMSD_SEL_PCI_HOST  4'h1
`define BMSD_SEL_HOST_PCI  4'h2
`define BMSD_SEL_RSV3      4'h3
`define BMSD_SEL_EMEM_SCR  4'h4
`define BMSD_SEL_I2C       4'h5
`define BMSD_SEL_SPI16     4'h6
`define BMSD_SEL_NAND      4'h7
`define BMSD_SEL_UART      4'h8
`define BMSD_SEL_EMEM_RAW  4'h9
`define BMSD_SEL_SLINK     4'ha
`define BMSD_SEL_RSVB      4'hb
`define BMSD_SEL_RSVC      4'hc
`define BMSD_SEL_RSVD      4'hd
`define BMSD_SEL_UART_FC   4'he
`define BMSD_SEL_SPI24     4'hf

// External-memory select codes.
`define BMSD_AEM_FIXED     3'h1
`define BMSD_AEM_USER0     3'h0
`define BMSD_AEM_USER3     3'h3
`define BMSD_AEM_USER4     3'h4
`define BMSD_AEM_USER5     3'h5

// Multiplier values (times the reference clock); zero means bypass.
`define BMSD_MUL_BYPASS    5'h00
`define BMSD_MUL_X15       5'h0f
`define BMSD_MUL_X16       5'h10
`define BMSD_MUL_X18       5'h12
`define BMSD_MUL_X20       5'h14
`define BMSD_MUL_X22       5'h16
`define BMSD_MUL_X25       5'h19
`define BMSD_MUL_X27       5'h1b
`define BMSD_MUL_X30       5'h1e

// Core-domain divider values.
`define BMSD_DIV_ONE       2'h1
`define BMSD_DIV_TWO       2'h2

// Default entry address and boot-path constraints.
`define BMSD_ENTRY_DEFAULT 32'h0010_0000
`define BMSD_I2C_ADDR_BITS 5'h10
`define BMSD_SPI_READ_BITS 4'h8

// Cycles the synchronised straps must settle before being latched.
`define BMSD_SETTLE_CYC    4'h4

`endif

// >>> shared/bmsd_pkg.sv
`default_nettype none
`include "bmsd_defs.svh"

package bmsd_pkg;

  typedef enum logic [3:0] {
    SRC_NONE,
    SRC_EMULATION,
    SRC_PCI,
    SRC_HOST_PORT,
    SRC_EXT_MEM_SCRIPT,
    SRC_EXT_MEM_RAW,
    SRC_EXT_MEM_DIRECT,
    SRC_I2C,
    SRC_SPI16,
    SRC_SPI24,
    SRC_NAND,
    SRC_UART,
    SRC_SERIAL_LINK
  } bmsd_source_t;

  typedef enum logic [1:0] {
    PH_SETTLE,
    PH_DONE
  } bmsd_phase_t;

  typedef struct packed {
    bmsd_phase_t                  phase;
    logic [3:0]                   settleCnt;
    logic                         planValid;
    bmsd_source_t                 bootSource;
    logic                         slaveRole;
    logic                         pllBypass;
    logic [4:0]                   pllMultiplier;
    logic [1:0]                   coreDomainDivider;
    logic [31:0]                  entryAddress;
    logic                         entryAddressValid;
    logic                         cacheOffDuringBoot;
    logic                         cacheOffOnExit;
    logic                         scriptFormat;
    logic                         autoInit;
    logic                         flowControl;
    logic                         extraSelectEnable;
    logic [4:0]                   i2cAddrBits;
    logic [3:0]                   spiReadBits;
    logic                         chipSelectTwoHold;
    logic                         reservedMode;
    logic [`BMSD_WORD_W-1:0]      latchedConfigWord;
  } bmsd_state_t;

endpackage

`default_nettype wire

// >>> rtl/bmsd_sync.sv
`timescale 1ns/10ps
`default_nettype none

// Two-flop synchroniser per bit for the asynchronous strap pins.
module bmsd_sync #(
  parameter int WIDTH = 12
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] async,
  output logic      [WIDTH-1:0] synced
);

  logic [WIDTH-1:0] stage1Reg;
  logic [WIDTH-1:0] stage2Reg;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always_ff @(posedge clk) begin
        if (!resetn) begin
          stage1Reg[i] <= 1'b0;
          stage2Reg[i] <= 1'b0;
        end else begin
          stage1Reg[i] <= async[i];
          stage2Reg[i] <= stage1Reg[i];
        end
      end
    end
  endgenerate

  assign synced = stage2Reg;

endmodule

`default_nettype wire

// >>> rtl/bmsd_strap_decoder.sv
// Notes on behaviour
// [RULE_01] 0000 emulation, master, bypass, /1; 0011/1011/1100/1101 reserved.
// [RULE_02] 0001 and PCI enable: PCI boot, no auto-init, slave, divider two.
// [RULE_03] Code 0010: host-port slave boot if PCI low, PCI auto-init if high.
// [RULE_04] 0101 I2C, 0110 SPI16, 1111 SPI24 and select; 1111/1010 force x20.
// [RULE_05] 1000 UART without flow control, 1110 with; master, divider two.
// [RULE_06] 0100 script external, 0111 NAND, 1001 raw external without entry.
// [RULE_07] User straps map 000..111 to x20,15,16,18,22,25,27,30; divider two.
// [RULE_08] User mapping only with fast-start and memory selects 0,3,4,5.
// [RULE_09] Modes with default entry 0x00100000 leave all caches off on exit.
// [RULE_10] Caches off in boot except direct boot, which keeps power-on state.
// [RULE_11] Fast-start: multiplier from the straps latched in the config word.
// [RULE_12] Board straps fast-start high for every PCI boot mode.
// [RULE_13] I2C path uses sixteen-bit EEPROM memory addresses only.
// [RULE_14] PCI auto-init boot needs an initialisation EEPROM on the I2C port.
// [RULE_15] Serial, NAND and script external images use script format.
// [RULE_16] NAND path holds chip select steadily asserted.
// [RULE_17] The NAND part is wired to chip select two.
// [RULE_18] SPI path clocks eight data bits per read: byte-wide parts only.
// [RULE_19] Emulation ignores fast-start, keeps PLL bypassed, awaits debugger.
// [RULE_20] Reserved combinations leave PLL bypassed and the device idle.
`timescale 1ns/10ps
`default_nettype none
`include "bmsd_defs.svh"

module bmsd_strap_decoder (
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire logic [3:0]            bootSelectStraps,
  input  wire logic                  pciEnableStrap,
  input  wire logic                  fastStartStrap,
  input  wire logic [2:0]            extMemSelectStraps,
  input  wire logic [2:0]            multiplierSelectStraps,
  output logic                       planValid,
  output bmsd_pkg::bmsd_source_t     bootSource,
  output logic                       slaveRole,
  output logic                       pllBypass,
  output logic [4:0]                 pllMultiplier,
  output logic [1:0]                 coreDomainDivider,
  output logic [31:0]                entryAddress,
  output logic                       entryAddressValid,
  output logic                       cacheOffDuringBoot,
  output logic                       cacheOffOnExit,
  output logic                       scriptFormat,
  output logic                       autoInit,
  output logic                       flowControl,
  output logic                       extraSelectEnable,
  output logic [4:0]                 i2cAddrBits,
  output logic [3:0]                 spiReadBits,
  output logic                       chipSelectTwoHold,
  output logic                       reservedMode,
  output logic [`BMSD_WORD_W-1:0]    latchedConfigWord
);

  ////////////////////////////////////////////////////////////////////////////

  logic [`BMSD_WORD_W-1:0] strapsAsync;
  logic [`BMSD_WORD_W-1:0] strapsSynced;

  assign strapsAsync = {multiplierSelectStraps, extMemSelectStraps,
                        fastStartStrap, pciEnableStrap, bootSelectStraps};

  bmsd_sync #(
    .WIDTH (`BMSD_WORD_W)
  ) u_sync (
    .clk    (clk),
    .resetn (resetn),
    .async  (strapsAsync),
    .synced (strapsSynced)
  );

  ////////////////////////////////////////////////////////////////////////////

  bmsd_pkg::bmsd_state_t s_reg;
  bmsd_pkg::bmsd_state_t s_next;

  logic [3:0] sel;
  logic       pci;
  logic       fast;
  logic [2:0] aem;
  logic [2:0] pllms;
  logic [4:0] userMul;
  logic [4:0] fastMul;
  logic       userSelect;
  logic       isMaster;

  assign sel   = strapsSynced[`BMSD_SEL_MSB:`BMSD_SEL_LSB];
  assign pci   = strapsSynced[`BMSD_PCI_BIT];
  assign fast  = strapsSynced[`BMSD_FAST_BIT];
  assign aem   = strapsSynced[`BMSD_AEM_MSB:`BMSD_AEM_LSB];
  assign pllms = strapsSynced[`BMSD_PLLMS_MSB:`BMSD_PLLMS_LSB];

  // The user mapping needs fast-start and one of four memory selects.
  assign userSelect = fast && (aem == `BMSD_AEM_USER0 || // RULE_08
                               aem == `BMSD_AEM_USER3 ||
                               aem == `BMSD_AEM_USER4 ||
                               aem == `BMSD_AEM_USER5);

  always_comb begin
    unique case (pllms) // RULE_07
      3'h0: userMul = `BMSD_MUL_X20;
      3'h1: userMul = `BMSD_MUL_X15;
      3'h2: userMul = `BMSD_MUL_X16;
      3'h3: userMul = `BMSD_MUL_X18;
      3'h4: userMul = `BMSD_MUL_X22;
      3'h5: userMul = `BMSD_MUL_X25;
      3'h6: userMul = `BMSD_MUL_X27;
      3'h7: userMul = `BMSD_MUL_X30;
    endcase
  end

  // Multiplier chosen from the latched straps when fast-start is set.
  always_comb begin
    fastMul = `BMSD_MUL_X20; // RULE_11
    if (userSelect) begin
      fastMul = userMul; // RULE_08
    end else if (aem == `BMSD_AEM_FIXED && !pci &&
                 sel == `BMSD_SEL_PCI_HOST) begin
      fastMul = `BMSD_MUL_X27;
    end else if (aem == `BMSD_AEM_FIXED && !pci &&
                 sel == `BMSD_SEL_RSV3) begin
      fastMul = `BMSD_MUL_X15;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    s_next   = s_reg;
    isMaster = 1'b1;
    unique case (s_reg.phase)
      bmsd_pkg::PH_SETTLE: begin
        if (s_reg.settleCnt != `BMSD_SETTLE_CYC) begin
          s_next.settleCnt = s_reg.settleCnt + 4'h1;
        end else begin
          s_next.phase             = bmsd_pkg::PH_DONE;
          s_next.planValid         = 1'b1;
          s_next.latchedConfigWord = strapsSynced; // RULE_11
          // Defaults: a normal loader boot on a divided clock, multiplied only when fast-start is set.
          s_next.bootSource         = bmsd_pkg::SRC_NONE;
          s_next.pllBypass          = !fast;
          s_next.pllMultiplier      = fast ? fastMul : `BMSD_MUL_BYPASS;
          s_next.coreDomainDivider  = `BMSD_DIV_TWO;
          s_next.entryAddress       = `BMSD_ENTRY_DEFAULT;
          s_next.entryAddressValid  = 1'b1;
          s_next.cacheOffDuringBoot = 1'b1; // RULE_10
          s_next.scriptFormat       = 1'b0;
          s_next.autoInit           = 1'b0;
          s_next.flowControl        = 1'b0;
          s_next.extraSelectEnable  = 1'b0;
          s_next.i2cAddrBits        = 5'h00;
          s_next.spiReadBits        = 4'h0;
          s_next.chipSelectTwoHold  = 1'b0;
          s_next.reservedMode       = 1'b0;
          unique case (sel)
            `BMSD_SEL_EMU: begin
              s_next.bootSource        = bmsd_pkg::SRC_EMULATION; // RULE_01
              s_next.pllBypass         = 1'b1; // RULE_19
              s_next.pllMultiplier     = `BMSD_MUL_BYPASS;
              s_next.coreDomainDivider = `BMSD_DIV_ONE; // RULE_01
            end
            `BMSD_SEL_PCI_HOST: begin
              if (pci) begin
                s_next.bootSource = bmsd_pkg::SRC_PCI; // RULE_02
                isMaster          = 1'b0;
              end else begin
                s_next.reservedMode = 1'b1; // RULE_02
              end
            end
            `BMSD_SEL_HOST_PCI: begin
              isMaster = 1'b0;
              if (pci) begin
                s_next.bootSource = bmsd_pkg::SRC_PCI; // RULE_03
                s_next.autoInit   = 1'b1; // RULE_14
                s_next.i2cAddrBits = `BMSD_I2C_ADDR_BITS; // RULE_13
              end else begin
                s_next.bootSource = bmsd_pkg::SRC_HOST_PORT; // RULE_03
              end
            end
            `BMSD_SEL_EMEM_SCR: begin
              if (fast) begin
                s_next.bootSource   = bmsd_pkg::SRC_EXT_MEM_SCRIPT; // RULE_06
                s_next.scriptFormat = 1'b1; // RULE_15
              end else begin
                // Direct boot skips the loader, so caches stay as powered up.
                s_next.bootSource         = bmsd_pkg::SRC_EXT_MEM_DIRECT;
                s_next.entryAddressValid  = 1'b0;
                s_next.cacheOffDuringBoot = 1'b0; // RULE_10
              end
            end
            `BMSD_SEL_I2C: begin
              s_next.bootSource   = bmsd_pkg::SRC_I2C; // RULE_04
              s_next.scriptFormat = 1'b1; // RULE_15
              s_next.i2cAddrBits  = `BMSD_I2C_ADDR_BITS; // RULE_13
            end
            `BMSD_SEL_SPI16: begin
              s_next.bootSource   = bmsd_pkg::SRC_SPI16; // RULE_04
              s_next.scriptFormat = 1'b1;
              s_next.spiReadBits  = `BMSD_SPI_READ_BITS; // RULE_18
            end
            `BMSD_SEL_NAND: begin
              s_next.bootSource        = bmsd_pkg::SRC_NAND; // RULE_06
              s_next.scriptFormat      = 1'b1;
              s_next.chipSelectTwoHold = 1'b1; // RULE_16
            end
            `BMSD_SEL_UART, `BMSD_SEL_UART_FC: begin
              s_next.bootSource   = bmsd_pkg::SRC_UART; // RULE_05
              s_next.scriptFormat = 1'b1;
              s_next.flowControl  = (sel == `BMSD_SEL_UART_FC); // RULE_05
            end
            `BMSD_SEL_EMEM_RAW: begin
              s_next.bootSource        = bmsd_pkg::SRC_EXT_MEM_RAW; // RULE_06
              s_next.entryAddress      = 32'h0000_0000;
              s_next.entryAddressValid = 1'b0; // RULE_06
            end
            `BMSD_SEL_SLINK: begin
              s_next.bootSource = bmsd_pkg::SRC_SERIAL_LINK;
              isMaster          = 1'b0;
              if (fast) begin
                s_next.pllMultiplier = `BMSD_MUL_X20; // RULE_04
              end
            end
            `BMSD_SEL_SPI24: begin
              s_next.bootSource        = bmsd_pkg::SRC_SPI24; // RULE_04
              s_next.scriptFormat      = 1'b1;
              s_next.extraSelectEnable = 1'b1; // RULE_04
              s_next.spiReadBits       = `BMSD_SPI_READ_BITS; // RULE_18
              if (fast) begin
                s_next.pllMultiplier = `BMSD_MUL_X20; // RULE_04
              end
            end
            default: begin
              s_next.reservedMode = 1'b1; // RULE_01
            end
          endcase
          // Reserved combinations: bypass, idle, nothing activated.
          if (s_next.reservedMode) begin
            s_next.bootSource        = bmsd_pkg::SRC_NONE; // RULE_20
            s_next.pllBypass         = 1'b1; // RULE_20
            s_next.pllMultiplier     = `BMSD_MUL_BYPASS;
            s_next.coreDomainDivider = `BMSD_DIV_ONE;
            s_next.entryAddress      = 32'h0000_0000;
            s_next.entryAddressValid = 1'b0;
            isMaster                 = 1'b1;
          end
          s_next.slaveRole = !isMaster;
          // Only modes parked on the default entry leave caches off on exit.
          s_next.cacheOffOnExit = s_next.entryAddressValid &&
            (s_next.entryAddress == `BMSD_ENTRY_DEFAULT); // RULE_09
        end
      end
      bmsd_pkg::PH_DONE: begin
        // The plan is fixed until the next reset, as the straps are.
        s_next = s_reg;
      end
      default: begin
        s_next.phase = bmsd_pkg::PH_SETTLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  assign planValid          = s_reg.planValid;
  assign bootSource         = s_reg.bootSource;
  assign slaveRole          = s_reg.slaveRole;
  assign pllBypass          = s_reg.pllBypass;
  assign pllMultiplier      = s_reg.pllMultiplier;
  assign coreDomainDivider  = s_reg.coreDomainDivider;
  assign entryAddress       = s_reg.entryAddress;
  assign entryAddressValid  = s_reg.entryAddressValid;
  assign cacheOffDuringBoot = s_reg.cacheOffDuringBoot;
  assign cacheOffOnExit     = s_reg.cacheOffOnExit;
  assign scriptFormat       = s_reg.scriptFormat;
  assign autoInit           = s_reg.autoInit;
  assign flowControl        = s_reg.flowControl;
  assign extraSelectEnable  = s_reg.extraSelectEnable;
  assign i2cAddrBits        = s_reg.i2cAddrBits;
  assign spiReadBits        = s_reg.spiReadBits;
  assign chipSelectTwoHold  = s_reg.chipSelectTwoHold;
  assign reservedMode       = s_reg.reservedMode;
  assign latchedConfigWord  = s_reg.latchedConfigWord;

endmodule

`default_nettype wire

// >>> test/bmsd_board_model.sv
`timescale 1ns/10ps
`default_nettype none

// Board strap resistors; wiggle models a noisy board after the plan is taken.
module bmsd_board_model (
  input  wire logic       clk,
  input  wire logic [3:0] reqSel,
  input  wire logic       reqPci,
  input  wire logic       reqFast,
  input  wire logic [2:0] reqAem,
  input  wire logic [2:0] reqMs,
  input  wire logic       wiggle,
  output var  logic [3:0] bootPins,
  output var  logic       pciPin,
  output var  logic       fastPin,
  output var  logic [2:0] aemPins,
  output var  logic [2:0] msPins
);
  logic flipReg = 1'b0;

  always_ff @(posedge clk) begin
    flipReg <= wiggle ? ~flipReg : 1'b0;
  end

  // The board always drives its straps. The boot image is taken to be in
  // script format, the auto-init EEPROM to sit on the I2C port and the NAND
  // part on chip select two; none of these is modelled here.
  always_comb begin
    {msPins, aemPins, fastPin, pciPin, bootPins} =
      {reqMs, reqAem, reqFast, reqPci, reqSel} ^ {12{flipReg}};
  end
endmodule
`default_nettype wire

// >>> test/bmsd_monitor.sv
`timescale 1ns/10ps
`default_nettype none
`include "bmsd_defs.svh"

module bmsd_monitor (
  input wire logic                   clk,
  input wire logic                   resetn,
  input wire logic                   planValid,
  input wire bmsd_pkg::bmsd_source_t bootSource,
  input wire logic                   slaveRole,
  input wire logic                   pllBypass,
  input wire logic [4:0]             pllMultiplier,
  input wire logic [1:0]             coreDomainDivider,
  input wire logic [31:0]            entryAddress,
  input wire logic                   entryAddressValid,
  input wire logic                   cacheOffDuringBoot,
  input wire logic                   cacheOffOnExit,
  input wire logic                   autoInit,
  input wire logic [4:0]             i2cAddrBits,
  input wire logic [3:0]             spiReadBits,
  input wire logic                   chipSelectTwoHold,
  input wire logic                   reservedMode,
  input wire logic [`BMSD_WORD_W-1:0] latchedConfigWord
);
  logic [3:0] sel;
  logic       pci;
  logic       fast;
  logic [2:0] aem;
  logic       rsv;
  logic       userAem;
  assign {aem, fast, pci, sel} = latchedConfigWord[8:0];
  assign rsv = sel == 4'h3 || sel == 4'hb || sel == 4'hc || sel == 4'hd
               || (sel == 4'h1 && !pci);
  assign userAem = aem == 3'h0 || aem == 3'h3 || aem == 3'h4 || aem == 3'h5;

  function automatic logic [4:0] mulOf(input logic [2:0] m);
    logic [4:0] t [8];
    t = '{5'h14, 5'h0f, 5'h10, 5'h12, 5'h16, 5'h19, 5'h1b, 5'h1e};
    return t[m];
  endfunction

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sequence release_seq;
    resetn && !$past(resetn);
  endsequence
  sequence plan_seq;
    !planValid ##[4:6] planValid;
  endsequence

  a_plan_timing: assert property (release_seq |-> plan_seq)
    else $error("plan not valid in time after reset");
  a_plan_holds: assert property (planValid |=> planValid
    && $stable(latchedConfigWord) && $stable(pllMultiplier)
    && $stable(bootSource))
    else $error("plan changed after it was latched");
  a_emu_plan: assert property (planValid && sel == 4'h0 |->
    bootSource == bmsd_pkg::SRC_EMULATION && pllBypass && !slaveRole
    && coreDomainDivider == 2'h1 && pllMultiplier == 5'h00)
    else $error("emulation plan wrong");
  a_reserved_idle: assert property (planValid && rsv |->
    reservedMode && bootSource == bmsd_pkg::SRC_NONE && pllBypass)
    else $error("reserved combination not idle");
  a_entry_cache: assert property (planValid && entryAddressValid |->
    entryAddress == 32'h0010_0000 && cacheOffOnExit)
    else $error("default entry without caches off");
  a_cache_boot: assert property (planValid && !rsv
    |-> cacheOffDuringBoot == !(sel == 4'h4 && !fast))
    else $error("boot cache state wrong");
  a_force_x20: assert property (planValid && fast
    && (sel == 4'ha || sel == 4'hf) |-> pllMultiplier == 5'h14)
    else $error("serial link or wide spi not x20");
  a_user_mult: assert property (planValid && fast && userAem
    && !rsv && sel != 4'h0 && sel != 4'ha && sel != 4'hf
    |-> pllMultiplier == mulOf(latchedConfigWord[11:9])
    && coreDomainDivider == 2'h2)
    else $error("user multiplier wrong");
  a_pci_auto: assert property (planValid && sel == 4'h2 && pci |->
    bootSource == bmsd_pkg::SRC_PCI && autoInit && slaveRole)
    else $error("pci auto init plan wrong");
  a_path_limits: assert property (planValid |->
    (bootSource == bmsd_pkg::SRC_I2C) == (sel == 4'h5)
    && (sel != 4'h5 || i2cAddrBits == 5'h10)
    && ((sel == 4'h6 || sel == 4'hf) == (spiReadBits == 4'h8))
    && (chipSelectTwoHold == (sel == 4'h7)))
    else $error("boot path limits wrong");
endmodule

bind bmsd_strap_decoder bmsd_monitor bmsd_monitor_inst (.clk, .resetn,
  .planValid, .bootSource, .slaveRole, .pllBypass, .pllMultiplier,
  .coreDomainDivider, .entryAddress, .entryAddressValid, .cacheOffDuringBoot,
  .cacheOffOnExit, .autoInit, .i2cAddrBits, .spiReadBits, .chipSelectTwoHold,
  .reservedMode, .latchedConfigWord);
`default_nettype wire

// >>> test/tb.sv
`timescale 1ns/10ps
`default_nettype none

module tb;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic wiggle = 1'b0;
  logic [3:0] rSel = 4'h0;
  logic rPci = 1'b0;
  logic rFast = 1'b0;
  logic [2:0] rAem = 3'h0;
  logic [2:0] rMs = 3'h0;
  logic [3:0] bootPins;
  logic pciPin, fastPin, planValid, slaveRole, pllBypass, entryAddressValid;
  logic cacheOffDuringBoot, cacheOffOnExit, scriptFormat, autoInit;
  logic flowControl, extraSelectEnable, chipSelectTwoHold, reservedMode;
  logic [2:0] aemPins, msPins;
  bmsd_pkg::bmsd_source_t bootSource;
  logic [4:0] pllMultiplier, i2cAddrBits;
  logic [1:0] coreDomainDivider;
  logic [31:0] entryAddress;
  logic [3:0] spiReadBits;
  logic [11:0] latchedConfigWord;
  logic [74:0] seenPlan;
  logic [74:0] expQ [$];
  logic gotPlan = 1'b0;
  logic [31:0] seed = 32'h662f0396;
  int n_mismatch = 0;
  int total_checks = 0;

  always #2 clk = ~clk;

  bmsd_board_model bmsd_board_model_inst (.clk, .reqSel(rSel), .reqPci(rPci),
    .reqFast(rFast), .reqAem(rAem), .reqMs(rMs), .wiggle, .bootPins, .pciPin,
    .fastPin, .aemPins, .msPins);
  bmsd_strap_decoder bmsd_strap_decoder_inst (.clk, .resetn,
    .bootSelectStraps(bootPins), .pciEnableStrap(pciPin),
    .fastStartStrap(fastPin), .extMemSelectStraps(aemPins),
    .multiplierSelectStraps(msPins), .planValid, .bootSource, .slaveRole,
    .pllBypass, .pllMultiplier, .coreDomainDivider, .entryAddress,
    .entryAddressValid, .cacheOffDuringBoot, .cacheOffOnExit, .scriptFormat,
    .autoInit, .flowControl, .extraSelectEnable, .i2cAddrBits, .spiReadBits,
    .chipSelectTwoHold, .reservedMode, .latchedConfigWord);

  assign seenPlan = {bootSource, slaveRole, pllBypass, pllMultiplier,
    coreDomainDivider, entryAddressValid, cacheOffOnExit, cacheOffDuringBoot,
    scriptFormat, autoInit, flowControl, extraSelectEnable, i2cAddrBits,
    spiReadBits, chipSelectTwoHold, reservedMode, latchedConfigWord,
    entryAddress};

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic [74:0] expPlan(input logic [3:0] s,
    input logic p, input logic f, input logic [2:0] a, input logic [2:0] m);
    logic [3:0] src;
    logic slv, byp, ev, sc, ai, fc, xs, cs, rsv;
    logic [4:0] mul, i2c;
    logic [3:0] spi;
    logic [1:0] dv;
    logic [4:0] t [8];
    t = '{5'h14, 5'h0f, 5'h10, 5'h12, 5'h16, 5'h19, 5'h1b, 5'h1e};
    src = bmsd_pkg::SRC_NONE;
    {slv, ai, fc, xs, cs, rsv, i2c, spi} = '0;
    byp = !f;
    dv = 2'h2;
    ev = 1'b1;
    sc = 1'b1;
    case (s)
      4'h0: {src, byp, dv, sc} = {bmsd_pkg::SRC_EMULATION, 1'b1, 2'h1, 1'b0};
      4'h1: {src, slv, sc, rsv} = {bmsd_pkg::SRC_PCI, 1'b1, 1'b0, !p};
      4'h2: {src, slv, sc, ai, i2c} = {p ? bmsd_pkg::SRC_PCI :
              bmsd_pkg::SRC_HOST_PORT, 1'b1, 1'b0, p, p ? 5'h10 : 5'h00};
      4'h4: {src, ev, sc} = {f ? bmsd_pkg::SRC_EXT_MEM_SCRIPT :
              bmsd_pkg::SRC_EXT_MEM_DIRECT, f, f};
      4'h5: {src, i2c} = {bmsd_pkg::SRC_I2C, 5'h10};
      4'h6: {src, spi} = {bmsd_pkg::SRC_SPI16, 4'h8};
      4'h7: {src, cs} = {bmsd_pkg::SRC_NAND, 1'b1};
      4'h8: src = bmsd_pkg::SRC_UART;
      4'he: {src, fc} = {bmsd_pkg::SRC_UART, 1'b1};
      4'h9: {src, ev, sc} = {bmsd_pkg::SRC_EXT_MEM_RAW, 1'b0, 1'b0};
      4'ha: {src, slv, sc} = {bmsd_pkg::SRC_SERIAL_LINK, 1'b1, 1'b0};
      4'hf: {src, xs, spi} = {bmsd_pkg::SRC_SPI24, 1'b1, 4'h8};
      default: rsv = 1'b1;
    endcase
    if (byp) mul = 5'h00;
    else if (s == 4'ha || s == 4'hf) mul = 5'h14;
    else if (a == 3'h1) mul = (s == 4'h1 && !p) ? 5'h1b : 5'h14;
    else if (a == 3'h2 || a > 3'h5) mul = 5'h14;
    else mul = t[m];
    if (rsv) begin
      src = bmsd_pkg::SRC_NONE;
      {slv, byp, mul, dv, ev, sc, ai, i2c} = {2'b01, 5'h00, 2'h1, 8'h00};
    end
    return {src, slv, byp, mul, dv, ev, ev, !(s == 4'h4 && !f), sc, ai, fc,
      xs, i2c, spi, cs, rsv, m, a, f, p, s,
      // Direct boot keeps the default address but flags it as unusable.
      (ev || (s == 4'h4 && !f)) ? 32'h0010_0000 : 32'h0};
  endfunction

  task automatic check(input logic [74:0] seen, input logic [74:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t plan seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    if (n_mismatch == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // The watcher pairs each latched plan with the oldest expectation.
  always @(negedge clk) begin
    if (!resetn) gotPlan = 1'b0;
    else if (planValid === 1'b1 && !gotPlan) begin
      gotPlan = 1'b1;
      check(seenPlan, expQ.size() > 0 ? expQ.pop_front() : {75{1'bx}});
    end
  end

  task automatic runBoot(input logic [3:0] s, input logic p, input logic f,
    input logic [2:0] a, input logic [2:0] m);
    int k;
    resetn = 1'b0;
    {rSel, rPci, rFast, rAem, rMs} = {s, p, f, a, m};
    expQ.push_back(expPlan(s, p, f, a, m));
    repeat (16) @(negedge clk);
    resetn = 1'b1;
    for (k = 0; k < 20 && planValid !== 1'b1; k++) @(negedge clk);
    if (planValid !== 1'b1) begin
      n_mismatch++;
      $display("MISMATCH t=%0t plan never became valid", $time);
      print_verdict();
    end else @(negedge clk);
  endtask

  initial begin
    int i;
    logic f;
    logic [2:0] userAem [4];
    userAem = '{3'h0, 3'h3, 3'h4, 3'h5};
    @(negedge clk);
    for (i = 0; i < 32; i++) begin
      seed = lfsr(seed);
      f = seed[0] | (i[4] && i[3:2] == 2'h0 && i[0] != i[1]);
      runBoot(i[3:0], i[4], f, seed[3:1], seed[6:4]);
    end
    for (i = 0; i < 8; i++) runBoot(4'h5, 1'b0, 1'b1, userAem[i[1:0]], i[2:0]);
    runBoot(4'h1, 1'b0, 1'b1, 3'h1, 3'h0);
    runBoot(4'h8, 1'b0, 1'b1, 3'h1, 3'h7);
    runBoot(4'h7, 1'b0, 1'b1, 3'h2, 3'h7);
    runBoot(4'h4, 1'b0, 1'b0, 3'h0, 3'h0);
    runBoot(4'h0, 1'b1, 1'b1, 3'h0, 3'h7);
    runBoot(4'ha, 1'b0, 1'b1, 3'h0, 3'h1);
    runBoot(4'hf, 1'b0, 1'b1, 3'h3, 3'h1);
    runBoot(4'h2, 1'b1, 1'b1, 3'h1, 3'h0);
    wiggle = 1'b1;
    repeat (10) @(negedge clk);
    check(seenPlan, expPlan(4'h2, 1'b1, 1'b1, 3'h1, 3'h0));
    print_verdict();
  end
endmodule
`default_nettype wire
